//--- hdl/aws_pkg.sv
package aws_pkg;

    // ****************************************************************
    // clock and time base
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 5;
    localparam int unsigned ODR_BASE_PERIOD_NS = 1250000;
    localparam int unsigned ODR_BASE_CYC      =
        ODR_BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned ODR_BASE_US       = ODR_BASE_PERIOD_NS / 1000;
    localparam int unsigned SLEEP_STEP_MS     = 320;
    localparam int unsigned SLEEP_STEP_SLOW_MS = 640;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_SLEEP_COUNT = 6'h29;
    localparam logic [5:0] IDX_RATE_CTRL   = 6'h2A;
    localparam logic [5:0] IDX_MODE_CTRL   = 6'h2B;
    localparam logic [5:0] IDX_INT_CTRL    = 6'h2C;
    localparam logic [5:0] IDX_INT_ENABLE  = 6'h2D;
    localparam logic [5:0] IDX_STATUS      = 6'h30;
    localparam logic [5:0] IDX_STATUS_CLR  = 6'h31;
    localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h32;
    localparam logic [5:0] IDX_FIFO_FLUSH  = 6'h33;
    localparam logic [5:0] IDX_STATE       = 6'h34;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int unsigned POS_ACTIVE     = 0;
    localparam int unsigned POS_WAKE_RATE  = 3;
    localparam int unsigned POS_SLEEP_RATE = 6;
    localparam int unsigned POS_AUTO_SLEEP = 2;
    localparam int unsigned POS_WAKE_SEL   = 3;
    localparam int unsigned POS_FIFO_GATE  = 7;
    localparam int unsigned POS_INT_EN     = 2;
    localparam int unsigned POS_FLUSH      = 0;
    localparam logic [7:0] RST_SLEEP_COUNT = 8'h00;
    localparam logic [2:0] RST_WAKE_RATE   = 3'h0;
    localparam logic [1:0] RST_SLEEP_RATE  = 2'h0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        AWS_STANDBY = 2'b00,
        AWS_WAKE    = 2'b01,
        AWS_SLEEP   = 2'b10
    } aws_mode_t;

    typedef struct packed {
        logic transient_event;
        logic orientation_event;
        logic tap_event;
        logic freefall_motion_event;
        logic fifo_event;
        logic wake_sleep_change_event;
        logic sample_ready_event;
    } aws_events_t;

endpackage

//--- hdl/aws_ctrl.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module aws_ctrl
    import aws_pkg::*;
#(
    parameter int unsigned BASE_CYC = ODR_BASE_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // embedded function events
    input  wire aws_events_t events_i,
    // sample timing and fifo gate
    output logic             sample_tick_o,
    output logic [2:0]       output_sample_rate_o,
    output logic             sleeping_o,
    output logic             fifo_accept_o,
    // interrupt
    output logic             irq_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        aws_mode_t   mode;
        logic [7:0]  sleep_delay_count;
        logic [2:0]  wake_rate_select;
        logic [1:0]  sleep_rate_select;
        logic        active;
        logic        auto_sleep_enable;
        logic        fifo_gate;
        logic [3:0]  wake_sel;
        logic [4:0]  int_en;
        logic [1:0]  status;
        logic [1:0]  irq_en;
        logic        gate_closed;
        logic [19:0] base_cnt;
        logic [9:0]  unit_cnt;
        logic [15:0] idle_cnt;
        logic        tick;
        logic [2:0]  rate;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        logic        accept;
        logic        sleeping;
    } aws_regs_t;

    aws_regs_t r_r;
    aws_regs_t r_nxt;

    // ****************************************************************
    // rate tables
    // ****************************************************************
    function automatic logic [9:0] rate_mult(input logic [2:0] code);
        case (code)
            3'h0:    rate_mult = 10'h001;
            3'h1:    rate_mult = 10'h002;
            3'h2:    rate_mult = 10'h004;
            3'h3:    rate_mult = 10'h008;
            3'h4:    rate_mult = 10'h010;
            3'h5:    rate_mult = 10'h040;
            3'h6:    rate_mult = 10'h080;
            default: rate_mult = 10'h200;
        endcase
    endfunction

    // sample ticks per count step, derived from the step times
    function automatic logic [15:0] step_ticks(input logic [2:0] code);
        int unsigned t;
        t = 0;
        if (code == 3'h7) begin
            t = (SLEEP_STEP_SLOW_MS * 1000) / (ODR_BASE_US * 512);
        end else begin
            t = (SLEEP_STEP_MS * 1000)
                / (ODR_BASE_US * int'(rate_mult(code)));
        end
        step_ticks = t[15:0];
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    logic        req;
    logic        wr;
    logic [5:0]  idx;
    logic        aligned;
    logic [3:0]  fn_ev;
    logic        restart;
    logic        wake_ev;
    logic [15:0] target;
    logic [23:0] target_full;
    logic [2:0]  eff_rate;
    logic        to_sleep;
    logic        to_wake;

    always_comb begin
        r_nxt = r_r;
        req     = wb_cyc_i & wb_stb_i;
        idx     = wb_adr_i[7:2];
        aligned = (wb_adr_i[1:0] == 2'h0);
        wr      = req & wb_we_i & r_r.ack & wb_sel_i[0] & aligned;
        fn_ev   = {events_i.transient_event, events_i.orientation_event,
                   events_i.tap_event, events_i.freefall_motion_event};
        // transition and sample-ready events are not looked at
        // a function event counts only while its enable bit is set
        restart = |(fn_ev & r_r.int_en[3:0])
                | (events_i.fifo_event & r_r.int_en[4]);
        wake_ev = |(fn_ev & r_r.int_en[3:0] & r_r.wake_sel);
        target_full = r_r.sleep_delay_count
                      * step_ticks(r_r.wake_rate_select);
        target      = target_full[15:0];
        to_sleep = 1'b0;
        to_wake  = 1'b0;

        // ************************************************************
        // sample tick generation at the effective rate
        // ************************************************************
        // standby parks the divider: first tick is a full period late
        r_nxt.tick = 1'b0;
        if (r_r.mode == AWS_STANDBY) begin
            r_nxt.base_cnt = 20'h00000;
            r_nxt.unit_cnt = 10'h000;
        end else if (r_r.base_cnt == 20'(BASE_CYC - 1)) begin
            r_nxt.base_cnt = 20'h00000;
            if (r_r.unit_cnt == rate_mult(r_r.rate) - 10'h001) begin
                r_nxt.unit_cnt = 10'h000;
                r_nxt.tick     = 1'b1;
            end else begin
                r_nxt.unit_cnt = r_r.unit_cnt + 10'h001;
            end
        end else begin
            r_nxt.base_cnt = r_r.base_cnt + 20'h00001;
        end

        // ************************************************************
        // wake/sleep mode machine
        // ************************************************************
        case (r_r.mode)
            AWS_STANDBY: begin
                r_nxt.idle_cnt = 16'h0000;
                if (r_r.active) begin
                    r_nxt.mode = AWS_WAKE;
                end
            end
            AWS_WAKE: begin
                if (!r_r.active) begin
                    r_nxt.mode = AWS_STANDBY;
                end else if (!r_r.auto_sleep_enable) begin
                    r_nxt.idle_cnt = 16'h0000;
                end else if (restart) begin
                    r_nxt.idle_cnt = 16'h0000;
                // checked before the tick, so a zero count sleeps at once
                end else if (r_r.idle_cnt >= target) begin
                    r_nxt.mode = AWS_SLEEP;
                    to_sleep   = 1'b1;
                end else if (r_r.tick) begin
                    r_nxt.idle_cnt = r_r.idle_cnt + 16'h0001;
                end
            end
            AWS_SLEEP: begin
                if (!r_r.active) begin
                    r_nxt.mode = AWS_STANDBY;
                end else if (wake_ev || !r_r.auto_sleep_enable) begin
                    r_nxt.mode     = AWS_WAKE;
                    r_nxt.idle_cnt = 16'h0000;
                    to_wake        = 1'b1;
                end
            end
            default: begin
                // an unused code falls back to standby
                r_nxt.mode = AWS_STANDBY;
            end
        endcase

        // sleep rate replaces the system rate while asleep
        eff_rate = (r_nxt.mode == AWS_SLEEP)
                 ? {1'b1, r_r.sleep_rate_select}
                 : r_r.wake_rate_select;
        if (eff_rate != r_r.rate) begin
            // restart the divider so the first tick has the new period
            r_nxt.base_cnt = 20'h00000;
            r_nxt.unit_cnt = 10'h000;
        end
        r_nxt.rate = eff_rate;
        // own flop, so the pin never carries decode glitches
        r_nxt.sleeping = (r_nxt.mode == AWS_SLEEP);

        // ************************************************************
        // fifo gate across rate changes
        // ************************************************************
        if (wr && idx == IDX_FIFO_FLUSH && wb_dat_i[POS_FLUSH]) begin
            r_nxt.gate_closed = 1'b0;
        end
        // close beats a flush in the same cycle, so no sample slips in
        if (r_r.fifo_gate && (to_sleep || to_wake)) begin
            r_nxt.gate_closed = 1'b1;
        end
        r_nxt.accept = (r_nxt.mode != AWS_STANDBY) & ~r_nxt.gate_closed;

        // ************************************************************
        // interrupt status, set wins over clear
        // ************************************************************
        if (wr && idx == IDX_STATUS_CLR) begin
            r_nxt.status = r_r.status & ~wb_dat_i[1:0];
        end
        if (to_sleep) begin
            r_nxt.status[0] = 1'b1;
        end
        if (to_wake) begin
            r_nxt.status[1] = 1'b1;
        end

        // ************************************************************
        // register writes, taken at the acknowledge edge
        // ************************************************************
        if (wr) begin
            case (idx)
                IDX_SLEEP_COUNT: begin
                    r_nxt.sleep_delay_count = wb_dat_i[7:0];
                end
                IDX_RATE_CTRL: begin
                    r_nxt.active            = wb_dat_i[POS_ACTIVE];
                    r_nxt.wake_rate_select  =
                        wb_dat_i[POS_WAKE_RATE +: 3];
                    r_nxt.sleep_rate_select =
                        wb_dat_i[POS_SLEEP_RATE +: 2];
                end
                IDX_MODE_CTRL: begin
                    r_nxt.auto_sleep_enable =
                        wb_dat_i[POS_AUTO_SLEEP];
                end
                IDX_INT_CTRL: begin
                    r_nxt.fifo_gate = wb_dat_i[POS_FIFO_GATE];
                    r_nxt.wake_sel  = wb_dat_i[POS_WAKE_SEL +: 4];
                end
                IDX_INT_ENABLE: begin
                    r_nxt.int_en = wb_dat_i[POS_INT_EN +: 5];
                end
                IDX_IRQ_ENABLE: begin
                    r_nxt.irq_en = wb_dat_i[1:0];
                end
                default: begin
                end
            endcase
        end
        r_nxt.irq = |(r_nxt.status & r_nxt.irq_en);

        // ************************************************************
        // wishbone answer: one wait state, unmapped reads give zero
        // ************************************************************
        r_nxt.ack = req & ~r_r.ack;
        if (req && !r_r.ack) begin
            r_nxt.dat = 32'h00000000;
            if (aligned) begin
                case (idx)
                    IDX_SLEEP_COUNT: r_nxt.dat[7:0] = r_r.sleep_delay_count;
                    IDX_RATE_CTRL: begin
                        r_nxt.dat[7:0] = {r_r.sleep_rate_select,
                                          r_r.wake_rate_select,
                                          2'h0, r_r.active};
                    end
                    IDX_MODE_CTRL: begin
                        r_nxt.dat[POS_AUTO_SLEEP] = r_r.auto_sleep_enable;
                    end
                    IDX_INT_CTRL: begin
                        r_nxt.dat[7:0] = {r_r.fifo_gate, r_r.wake_sel,
                                          3'h0};
                    end
                    IDX_INT_ENABLE: r_nxt.dat[7:0] = {1'b0, r_r.int_en,
                                                      2'h0};
                    IDX_STATUS:     r_nxt.dat[1:0] = r_r.status;
                    IDX_IRQ_ENABLE: r_nxt.dat[1:0] = r_r.irq_en;
                    IDX_STATE: begin
                        r_nxt.dat[7:0] = {r_r.gate_closed, r_r.rate,
                                          2'h0, r_r.mode};
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            // cleared in the ack cycle too, so read data never lingers
            r_nxt.dat = 32'h00000000;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r_r                   <= '0;
            r_r.mode              <= AWS_STANDBY;
            r_r.sleep_delay_count <= RST_SLEEP_COUNT;
            r_r.wake_rate_select  <= RST_WAKE_RATE;
            r_r.sleep_rate_select <= RST_SLEEP_RATE;
            r_r.auto_sleep_enable <= 1'b0;
            r_r.rate              <= RST_WAKE_RATE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ****************************************************************
    // outputs, every one straight from the state register
    // ****************************************************************
    assign wb_ack_o             = r_r.ack;
    assign wb_dat_o             = r_r.dat;
    assign sample_tick_o        = r_r.tick;
    assign output_sample_rate_o = r_r.rate;
    assign sleeping_o           = r_r.sleeping;
    assign fifo_accept_o        = r_r.accept;
    assign irq_o                = r_r.irq;

endmodule

//--- testbench/aws_ctrl_sva.sv
`timescale 1ns/1ps
module aws_ctrl_sva
    import aws_pkg::*;
#(
    parameter int unsigned BASE_CYC = ODR_BASE_CYC
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // events and outputs
    input wire aws_events_t events_i,
    input wire logic        sample_tick_o,
    input wire logic [2:0]  output_sample_rate_o,
    input wire logic        sleeping_o,
    input wire logic        fifo_accept_o,
    input wire logic        irq_o
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    dat_width_a: assert property (
        wb_dat_o[31:8] == 24'h0)
        else $error("register wider than a byte");
    tick_pulse_a: assert property (
        sample_tick_o |=> !sample_tick_o)
        else $error("sample tick longer than one cycle");
    sleep_rate_a: assert property (
        sleeping_o && $past(sleeping_o) |-> output_sample_rate_o[2])
        else $error("sleep rate not in force");
    // a write lands at ack and acts one edge later, so skip both
    no_false_wake_a: assert property (
        sleeping_o && !wb_cyc_i && !$past(wb_cyc_i)
        && events_i[6:3] == 4'h0 |=> sleeping_o)
        else $error("sleep left without wake event");
endmodule

bind aws_ctrl aws_ctrl_sva #(.BASE_CYC(BASE_CYC)) i_aws_ctrl_sva (
    .clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .events_i,
    .sample_tick_o, .output_sample_rate_o, .sleeping_o,
    .fifo_accept_o, .irq_o
);

//--- testbench/aws_host.sv
`timescale 1ns/1ps
module aws_host (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'hF;
        wb_dat_o = 32'h0;
    end

    // one classic cycle, held until ack is sampled at an edge
    task automatic xfer(input logic we, input logic [5:0] idx,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= {idx, 2'b00};
        wb_dat_o <= {24'h0, d};
        // no cycle count is assumed; the bench watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_i !== 1'b1);
        q = wb_dat_i[7:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
        // released lines must not look like a held request
        wb_adr_o <= ~wb_adr_o;
        wb_dat_o <= ~wb_dat_o;
    endtask
endmodule

//--- testbench/tb_aws_ctrl.sv
`timescale 1ns/1ps
module tb_aws_ctrl
    import aws_pkg::*;
;
    logic        clk_i;
    logic        sys_rst_i;
    logic        cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic        ack, tick, sleeping, accept, irq;
    logic [2:0]  rate;
    aws_events_t events;
    int          failures;
    int          compares;

    aws_ctrl #(.BASE_CYC(4)) i_aws_ctrl (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .events_i(events), .sample_tick_o(tick),
        .output_sample_rate_o(rate), .sleeping_o(sleeping),
        .fifo_accept_o(accept), .irq_o(irq)
    );
    aws_host i_aws_host (
        .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
        .wb_ack_i(ack), .wb_dat_i(rdat)
    );

    always #2.5 clk_i = ~clk_i;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        i_aws_host.xfer(1'b1, idx, d, q);
    endtask
    task rchk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        i_aws_host.xfer(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask
    task skip(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wt(input int n);
        repeat (n) begin
            do @(posedge clk_i); while (tick !== 1'b1);
        end
    endtask
    task pulse(input int i);
        @(posedge clk_i);
        events <= aws_events_t'(7'h01 << i);
        @(posedge clk_i);
        events <= '0;
        @(posedge clk_i);
    endtask
    task end_of_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_regs;
        rchk(IDX_SLEEP_COUNT, RST_SLEEP_COUNT);
        rchk(IDX_RATE_CTRL, 8'h00);
        rchk(IDX_MODE_CTRL, 8'h00);
        wr(IDX_SLEEP_COUNT, 8'hA5);
        rchk(IDX_SLEEP_COUNT, 8'hA5);
        wr(6'h00, 8'hFF);
        rchk(6'h00, 8'h00);
        rchk(IDX_STATUS_CLR, 8'h00);
        $display("regs done");
    endtask
    // steps per count: 4, 2 and 1 ticks at wake rates 5, 6, 7
    // sleep rates 4, 5, 6 differ, so the override is visible
    task t_sleep;
        logic [2:0] w;
        logic [1:0] s;
        for (int k = 0; k < 3; k++) begin
            w = 3'(5 + k);
            s = 2'(k);
            wr(IDX_RATE_CTRL, {s, w, 3'h0});
            wr(IDX_STATUS_CLR, 8'h03);
            wr(IDX_SLEEP_COUNT, 8'h01);
            wr(IDX_MODE_CTRL, 8'h04);
            wr(IDX_RATE_CTRL, {s, w, 3'h1});
            wt((4 >> k) - 1);
            skip(3);
            chk(sleeping, 1'b0);
            chk(rate, w);
            wt(1);
            skip(3);
            chk(sleeping, 1'b1);
            chk(rate, {1'b1, s});
            rchk(IDX_STATUS, 8'h01);
        end
        chk(irq, 1'b0);
        wr(IDX_IRQ_ENABLE, 8'h03);
        skip(2);
        chk(irq, 1'b1);
        rchk(IDX_IRQ_ENABLE, 8'h03);
        wr(IDX_STATUS_CLR, 8'h01);
        skip(2);
        chk(irq, 1'b0);
        $display("sleep and irq done");
    endtask
    task t_restart;
        wr(IDX_RATE_CTRL, 8'h28);
        wr(IDX_INT_ENABLE, 8'h40);
        wr(IDX_RATE_CTRL, 8'h29);
        wt(3);
        pulse(2);
        wt(3);
        skip(3);
        chk(sleeping, 1'b0);
        wt(1);
        skip(3);
        chk(sleeping, 1'b1);
        $display("restart done");
    endtask
    task t_wake;
        wr(IDX_RATE_CTRL, 8'h30);
        wr(IDX_SLEEP_COUNT, 8'h00);
        wr(IDX_INT_ENABLE, 8'h7C);
        wr(IDX_INT_CTRL, 8'hB8);
        rchk(IDX_INT_ENABLE, 8'h7C);
        rchk(IDX_INT_CTRL, 8'hB8);
        wr(IDX_STATUS_CLR, 8'h03);
        wr(IDX_RATE_CTRL, 8'h31);
        skip(5);
        chk(sleeping, 1'b1);
        chk(rate, 3'h4);
        chk(accept, 1'b0);
        rchk(IDX_STATE, 8'hC2);
        wr(IDX_FIFO_FLUSH, 8'h01);
        skip(2);
        chk(accept, 1'b1);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            chk(sleeping, i < 3 || i > 5);
            skip(5);
        end
        rchk(IDX_STATUS, 8'h03);
        chk(irq, 1'b1);
        $display("wake done");
    endtask
    task t_noauto;
        wr(IDX_MODE_CTRL, 8'h00);
        skip(20);
        chk(sleeping, 1'b0);
        chk(rate, 3'h6);
        wr(IDX_FIFO_FLUSH, 8'h01);
        skip(2);
        chk(accept, 1'b1);
        wr(IDX_RATE_CTRL, 8'h30);
        skip(2);
        chk(accept, 1'b0);
        chk(sleeping, 1'b0);
        $display("no auto sleep done");
    endtask

    initial begin
        clk_i = 1'b0;
        sys_rst_i = 1'b1;
        events = '0;
        failures = 0;
        compares = 0;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_sleep();
        t_restart();
        t_wake();
        t_noauto();
        end_of_test();
    end

    // tests need about 6000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        end_of_test();
    end
endmodule
